// ---- uss_fifo.sv ----
// Shared constants and the capture FIFO for the shift and storage register
`timescale 1ns/1ps

package uss_pkg;
   localparam int WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [WIDTH-1:0] STAGE_RST = 8'h00;
   localparam int MSB = WIDTH - 1;
   // Positions inside the synchronised pin vector
   localparam int SYNC_W = WIDTH + 7;
   localparam int SY_CLK = WIDTH + 6;
   localparam int SY_S1 = WIDTH + 5;
   localparam int SY_S0 = WIDTH + 4;
   localparam int SY_DS0 = WIDTH + 3;
   localparam int SY_DS7 = WIDTH + 2;
   localparam int SY_OEA = WIDTH + 1;
   localparam int SY_OEB = WIDTH;
   // Mode as {mode_select_high, mode_select_low}, Gray along the cycle
   typedef enum logic [1:0]
   {
      MODE_HOLD = 2'h0,
      MODE_SHR = 2'h1,
      MODE_LOAD = 2'h3,
      MODE_SHL = 2'h2
   } uss_mode_e;
endpackage

module uss_fifo
#(
   parameter int W = 8,
   parameter int D = 16
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(D);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   logic [W-1:0] mem [D];
   logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic full_r, full_nxt;
   logic room_r, room_nxt;
   logic ov_r, ov_nxt;
   logic [W-1:0] od_r, od_nxt;
   logic push, pop;

   assign push = in_valid && !full_r;
   assign pop = (cnt_r != '0) && (!ov_r || out_ready);
   assign in_ready = room_r;
   assign out_valid = ov_r;
   assign out_data = od_r;

   always_comb
   begin
      wr_ptr_nxt = push ? wr_ptr_r + PTR_ONE : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + PTR_ONE : rd_ptr_r;
      cnt_nxt = cnt_r;
      if (push && !pop)
      begin
         cnt_nxt = cnt_r + CNT_ONE;
      end
      else if (pop && !push)
      begin
         cnt_nxt = cnt_r - CNT_ONE;
      end
      full_nxt = (cnt_nxt == CNT_FULL);
      room_nxt = (cnt_nxt != CNT_FULL);
      ov_nxt = pop ? 1'b1 : (ov_r && !out_ready);
      od_nxt = pop ? mem[rd_ptr_r] : od_r;
      if (rst)
      begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         cnt_nxt = '0;
         full_nxt = 1'b0;
         room_nxt = 1'b1;
         ov_nxt = 1'b0;
         od_nxt = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      room_r <= room_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
      if (push)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   property p_full_count;
      @(posedge mclk) disable iff (rst)
      full_r |-> (cnt_r == CNT_FULL) && !room_r;
   endproperty
   a_full_count: assert property (p_full_count)
      else $error("fifo full flag without full count");
endmodule // uss_fifo

// ---- uss_shift_reg.sv ----
// Eight-stage universal shift and storage register with bidirectional pins
`timescale 1ns/1ps
// Functional notes
// - Eight edge-triggered storage stages numbered 0 to 7 form one register.
// - Low clear input forces all stages low at once, ignoring mode and clock.
// - Besides clear, stored state changes only on a rising shift clock edge.
// - Both selects high: rising edge loads parallel pin n into stage n.
// - Select high low, low high: shift right, serial in enters stage 0.
// - Select high high, low low: shift left, serial in enters stage 7.
// - Both selects low: all stages hold their value.
// - When enabled, each stage drives its matching parallel pin.
// - Either output enable high puts all parallel pins in high impedance.
// - Shift, hold, load and clear still work while pins are released.
// - Both selects high also release the pins for an external load.
// - Stage 0 and stage 7 appear on two always driven serial outputs.
module uss_shift_reg
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register control pins
   input wire logic shift_clock,
   input wire logic async_clear_n,
   input wire logic mode_select_low,
   input wire logic mode_select_high,
   input wire logic right_shift_serial_in,
   input wire logic left_shift_serial_in,
   input wire logic output_enable_a_n,
   input wire logic output_enable_b_n,
   // Parallel pins
   input wire logic [uss_pkg::MSB:0] parallel_bidir_pins_in,
   output logic [uss_pkg::MSB:0] parallel_bidir_pins_out,
   output logic [uss_pkg::MSB:0] parallel_bidir_pins_oe,
   // Serial outputs
   output logic stage0_serial_out,
   output logic stage7_serial_out,
   // Status
   output logic [1:0] current_mode,
   output logic capture_lost,
   input wire logic capture_lost_clr,
   // Capture stream of register contents
   output logic [uss_pkg::MSB:0] capture_data,
   output logic capture_valid,
   input wire logic capture_ready,
   output logic capture_room
);
   logic [uss_pkg::SYNC_W-1:0] sync_nxt, sync1_r, sync2_r;
   logic clr_meta_r, clr_ok_r;
   logic clk_prev_r, clk_prev_nxt;
   logic [uss_pkg::MSB:0] stage_r, stage_nxt;
   logic upd_r, upd_nxt;
   logic [uss_pkg::MSB:0] oe_r, oe_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic lost_r, lost_nxt;
   logic [uss_pkg::MSB:0] pins_s;
   logic clk_s, s0_s, s1_s, ds0_s, ds7_s, oea_s, oeb_s;
   logic rise, act, drive;
   uss_pkg::uss_mode_e mode;

   // Pin synchronisers
   assign sync_nxt = {shift_clock, mode_select_high, mode_select_low,
      right_shift_serial_in, left_shift_serial_in, output_enable_a_n,
      output_enable_b_n, parallel_bidir_pins_in};

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= sync_nxt;
         sync2_r <= sync1_r;
      end
   end

   assign clk_s = sync2_r[uss_pkg::SY_CLK];
   assign s1_s = sync2_r[uss_pkg::SY_S1];
   assign s0_s = sync2_r[uss_pkg::SY_S0];
   assign ds0_s = sync2_r[uss_pkg::SY_DS0];
   assign ds7_s = sync2_r[uss_pkg::SY_DS7];
   assign oea_s = sync2_r[uss_pkg::SY_OEA];
   assign oeb_s = sync2_r[uss_pkg::SY_OEB];
   assign pins_s = sync2_r[uss_pkg::MSB:0];
   assign mode = uss_pkg::uss_mode_e'({s1_s, s0_s});

   // Clear release is synchronised; assertion acts at once
   always_ff @(posedge mclk or negedge async_clear_n)
   begin
      if (!async_clear_n)
      begin
         clr_meta_r <= 1'b0;
         clr_ok_r <= 1'b0;
      end
      else
      begin
         clr_meta_r <= 1'b1;
         clr_ok_r <= clr_meta_r;
      end
   end

   // Rising edge of the shift clock
   assign rise = clk_s && !clk_prev_r;
   assign act = rise && clr_ok_r;

   always_comb
   begin
      clk_prev_nxt = rst ? 1'b0 : clk_s;
   end

   always_ff @(posedge mclk)
   begin
      clk_prev_r <= clk_prev_nxt;
   end

   // Stage update
   always_comb
   begin
      stage_nxt = stage_r;
      upd_nxt = 1'b0;
      if (rst)
      begin
         stage_nxt = uss_pkg::STAGE_RST;
      end
      else if (act)
      begin
         case (mode)
            uss_pkg::MODE_LOAD:
            begin
               stage_nxt = pins_s;
               upd_nxt = 1'b1;
            end
            uss_pkg::MODE_SHR:
            begin
               stage_nxt = {stage_r[uss_pkg::MSB-1:0], ds0_s};
               upd_nxt = 1'b1;
            end
            uss_pkg::MODE_SHL:
            begin
               stage_nxt = {ds7_s, stage_r[uss_pkg::MSB:1]};
               upd_nxt = 1'b1;
            end
            uss_pkg::MODE_HOLD:
            begin
               stage_nxt = stage_r;
            end
            default:
            begin
               stage_nxt = stage_r;
            end
         endcase
      end
   end

   // Eight stages, cleared directly by the clear pin
   always_ff @(posedge mclk or negedge async_clear_n)
   begin
      if (!async_clear_n)
      begin
         stage_r <= uss_pkg::STAGE_RST;
         upd_r <= 1'b0;
      end
      else
      begin
         stage_r <= stage_nxt;
         upd_r <= upd_nxt;
      end
   end

   // Pin drivers, one enable per pin
   assign drive = !(oea_s || oeb_s) && !(s0_s && s1_s);

   generate
      for (genvar i = 0; i <= uss_pkg::MSB; i++)
      begin : g_oe
         always_comb
         begin
            oe_nxt[i] = rst ? 1'b0 : drive;
         end
      end
   endgenerate

   // Status flags; a new loss wins over its clear
   always_comb
   begin
      mode_nxt = rst ? 2'h0 : {s1_s, s0_s};
      lost_nxt = lost_r;
      if (rst)
      begin
         lost_nxt = 1'b0;
      end
      else if (upd_r && !capture_room)
      begin
         lost_nxt = 1'b1;
      end
      else if (capture_lost_clr)
      begin
         lost_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      oe_r <= oe_nxt;
      mode_r <= mode_nxt;
      lost_r <= lost_nxt;
   end

   assign parallel_bidir_pins_out = stage_r;
   assign parallel_bidir_pins_oe = oe_r;
   assign stage0_serial_out = stage_r[0];
   assign stage7_serial_out = stage_r[uss_pkg::MSB];
   assign current_mode = mode_r;
   assign capture_lost = lost_r;

   // Capture FIFO of every clocked change
   uss_fifo
   #(
      .W(uss_pkg::WIDTH),
      .D(uss_pkg::FIFO_DEPTH)
   )
   u_fifo
   (
      .mclk(mclk),
      .rst(rst),
      .in_valid(upd_r),
      .in_ready(capture_room),
      .in_data(stage_r),
      .out_valid(capture_valid),
      .out_ready(capture_ready),
      .out_data(capture_data)
   );

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst || !async_clear_n);

   property p_clear;
      @(posedge mclk) disable iff (rst)
      !async_clear_n |-> (stage_r == uss_pkg::STAGE_RST);
   endproperty
   a_clear: assert property (p_clear)
      else $error("stages not cleared while clear is low");

   property p_edge_only;
      !act |=> $stable(stage_r);
   endproperty
   a_edge_only: assert property (p_edge_only)
      else $error("stages changed without a shift clock edge");

   property p_load;
      act && (mode == uss_pkg::MODE_LOAD) |=> stage_r == $past(pins_s);
   endproperty
   a_load: assert property (p_load)
      else $error("parallel load took wrong data");

   property p_shr;
      act && (mode == uss_pkg::MODE_SHR) |=>
         stage_r == {$past(stage_r[uss_pkg::MSB-1:0]), $past(ds0_s)};
   endproperty
   a_shr: assert property (p_shr)
      else $error("shift right result wrong");

   property p_shl;
      act && (mode == uss_pkg::MODE_SHL) |=>
         stage_r == {$past(ds7_s), $past(stage_r[uss_pkg::MSB:1])};
   endproperty
   a_shl: assert property (p_shl)
      else $error("shift left result wrong");

   property p_hold;
      (mode == uss_pkg::MODE_HOLD) |=> $stable(stage_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold mode changed the stages");

   property p_drive;
      !oea_s && !oeb_s && !(s0_s && s1_s) |=> (&parallel_bidir_pins_oe);
   endproperty
   a_drive: assert property (p_drive)
      else $error("pins not driven while enabled");

   property p_release;
      (oea_s || oeb_s) |=> (parallel_bidir_pins_oe == '0);
   endproperty
   a_release: assert property (p_release)
      else $error("pins driven while an output enable is high");

   property p_load_release;
      (s0_s && s1_s) |=> (parallel_bidir_pins_oe == '0);
   endproperty
   a_load_release: assert property (p_load_release)
      else $error("pins driven in load mode");

   property p_released_shift;
      act && oea_s && (mode == uss_pkg::MODE_SHR) |=> upd_r;
   endproperty
   a_released_shift: assert property (p_released_shift)
      else $error("no update while pins released");

   property p_serial;
      act && (mode == uss_pkg::MODE_SHR) |=>
         stage0_serial_out == $past(ds0_s) &&
         stage7_serial_out == $past(stage_r[uss_pkg::MSB-1]);
   endproperty
   a_serial: assert property (p_serial)
      else $error("serial outputs do not follow the end stages");

   c_load: cover property (act && mode == uss_pkg::MODE_LOAD);
   c_shr: cover property (act && mode == uss_pkg::MODE_SHR);
   c_shl: cover property (act && mode == uss_pkg::MODE_SHL);
   c_full: cover property (!capture_room);
endmodule // uss_shift_reg

// ---- uss_bus_model.sv ----
// Bus logic model that shares the parallel pins with the register
`timescale 1ns/1ps
module uss_bus_model
(
   // Clock
   input wire logic mclk,
   // Register side of the pins
   input wire logic [7:0] dev_data,
   input wire logic [7:0] dev_oe,
   // Bus logic side
   input wire logic host_drive,
   input wire logic [7:0] host_data,
   // Resolved pin levels
   output logic [7:0] pin_level
);
   logic [7:0] last_r = 8'h00;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (dev_oe[i] && host_drive)
            pin_level[i] = 1'bx;
         else if (dev_oe[i])
            pin_level[i] = dev_data[i];
         else if (host_drive)
            pin_level[i] = host_data[i];
         else
            pin_level[i] = ~last_r[i];
      end
   end
   // Released pins toggle so a stale level is never seen
   always @(negedge mclk)
      last_r <= pin_level;
endmodule // uss_bus_model

// ---- uss_shift_reg_tb.sv ----
// Self-checking bench for the shift and storage register
`timescale 1ns/1ps
module uss_shift_reg_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic sclk = 1'b0;
   logic clr_n = 1'b1;
   logic s_lo = 1'b0;
   logic s_hi = 1'b0;
   logic ds0 = 1'b0;
   logic ds7 = 1'b0;
   logic oea_n = 1'b0;
   logic oeb_n = 1'b0;
   logic host_drive = 1'b0;
   logic [7:0] host_data = 8'h00;
   logic lost_clr = 1'b0;
   logic cap_ready = 1'b0;
   logic [7:0] pins_in, pins_out, pins_oe, cap_data;
   logic q0, q7, lost, cap_valid, cap_room;
   logic [1:0] cur_mode;
   logic [7:0] exp_r = 8'h00;
   logic [7:0] expq[$];
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #12.5 mclk = ~mclk;
   uss_shift_reg dut
   (
      .mclk(mclk), .rst(rst), .shift_clock(sclk), .async_clear_n(clr_n),
      .mode_select_low(s_lo), .mode_select_high(s_hi),
      .right_shift_serial_in(ds0), .left_shift_serial_in(ds7),
      .output_enable_a_n(oea_n), .output_enable_b_n(oeb_n),
      .parallel_bidir_pins_in(pins_in), .parallel_bidir_pins_out(pins_out),
      .parallel_bidir_pins_oe(pins_oe), .stage0_serial_out(q0),
      .stage7_serial_out(q7), .current_mode(cur_mode),
      .capture_lost(lost), .capture_lost_clr(lost_clr),
      .capture_data(cap_data), .capture_valid(cap_valid),
      .capture_ready(cap_ready), .capture_room(cap_room)
   );
   uss_bus_model bus
   (
      .mclk(mclk), .dev_data(pins_out), .dev_oe(pins_oe),
      .host_drive(host_drive), .host_data(host_data), .pin_level(pins_in)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      cmp_count++;
      if (got !== want)
      begin
         failures++;
         $display("BAD t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic set_mode(input logic [1:0] m);
      {s_hi, s_lo} = m;
      idle(4);
   endtask
   task automatic edge_pulse;
      sclk = 1'b1;
      idle(3);
      sclk = 1'b0;
      idle(4);
   endtask
   // One shift clock edge in mode m, then check the stages
   task automatic step(input logic [1:0] m, input logic d0, input logic d7);
      ds0 = d0;
      ds7 = d7;
      set_mode(m);
      edge_pulse();
      case (m)
         2'h1: exp_r = {exp_r[6:0], d0};
         2'h2: exp_r = {d7, exp_r[7:1]};
         2'h3: exp_r = host_data;
         default: exp_r = exp_r;
      endcase
      if (m != 2'h0 && expq.size() < 17)
         expq.push_back(exp_r);
      chk(pins_out, exp_r);
      chk({7'h00, q0}, {7'h00, exp_r[0]});
      chk({7'h00, q7}, {7'h00, exp_r[7]});
      chk({6'h00, cur_mode}, {6'h00, m});
   endtask
   task automatic results;
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end
   initial
   begin
      idle(12);
      rst = 1'b0;
      idle(4);
      chk(pins_out, 8'h00);
      chk(pins_oe, 8'hFF);
      host_data = 8'hA5;
      set_mode(2'h3);
      chk(pins_oe, 8'h00);
      host_drive = 1'b1;
      step(2'h3, 1'b0, 1'b0);
      host_drive = 1'b0;
      set_mode(2'h0);
      chk(pins_oe, 8'hFF);
      step(2'h0, 1'b1, 1'b1);
      sclk = 1'b1;
      idle(4);
      set_mode(2'h1);
      chk(pins_out, exp_r);
      sclk = 1'b0;
      idle(4);
      for (int i = 0; i < 8; i++)
         step(2'h1, i[0], 1'b0);
      for (int i = 0; i < 8; i++)
         step(2'h2, 1'b0, i[1]);
      step(2'h2, 1'b0, q0);
      oea_n = 1'b1;
      set_mode(2'h0);
      chk(pins_oe, 8'h00);
      step(2'h1, 1'b1, 1'b0);
      host_data = 8'h81;
      host_drive = 1'b1;
      step(2'h3, 1'b0, 1'b0);
      host_drive = 1'b0;
      oea_n = 1'b0;
      oeb_n = 1'b1;
      set_mode(2'h0);
      chk(pins_oe, 8'h00);
      oeb_n = 1'b0;
      chk({7'h00, cap_room}, 8'h00);
      chk({7'h00, lost}, 8'h01);
      while (expq.size() > 0)
      begin
         chk({7'h00, cap_valid}, 8'h01);
         chk(cap_data, expq.pop_front());
         cap_ready = 1'b1;
         idle(1);
         cap_ready = 1'b0;
         idle(3);
      end
      chk({7'h00, cap_valid}, 8'h00);
      chk({7'h00, cap_room}, 8'h01);
      lost_clr = 1'b1;
      idle(1);
      lost_clr = 1'b0;
      idle(1);
      chk({7'h00, lost}, 8'h00);
      clr_n = 1'b0;
      #2;
      chk({6'h00, q7, q0}, 8'h00);
      idle(1);
      exp_r = 8'h00;
      ds0 = 1'b1;
      set_mode(2'h1);
      edge_pulse();
      chk(pins_out, 8'h00);
      clr_n = 1'b1;
      idle(4);
      step(2'h1, 1'b1, 1'b0);
      results();
   end
endmodule // uss_shift_reg_tb
